// File: hdl/boot_loader_defs.svh
`ifndef BOOT_LOADER_DEFS_SVH
`define BOOT_LOADER_DEFS_SVH

// Handshake bytes on the serial link
`define ACK_BYTE 8'hCC
`define NAK_BYTE 8'h33
`define FILL_BYTE 8'h00

// Command codes carried in the first data byte
`define CMD_PING 8'h20
`define CMD_DOWNLOAD 8'h21
`define CMD_RUN 8'h22
`define CMD_STATUS_QUERY 8'h23
`define CMD_SEND_DATA 8'h24
`define CMD_RESET 8'h25

// Packet length bytes, counting length and sum bytes
`define LEN_PING 8'h03
`define LEN_STATUS_QUERY 8'h03
`define LEN_DOWNLOAD 8'h0B
`define LEN_RUN 8'h07
`define LEN_RESET 8'h03
`define LEN_MIN 8'h03
`define LEN_HEADER 8'h02
`define LEN_STATUS_REPLY 8'h03

// Global status codes
`define STAT_SUCCESS 8'h40
`define STAT_UNKNOWN_CMD 8'h41
`define STAT_INVALID_CMD 8'h42
`define STAT_FLASH_FAIL 8'h43

// Reset value of the global status
`define STAT_RESET 8'h40

`endif

// File: hdl/boot_loader_pkg.sv
package boot_loader_pkg;

  // Main sequencer states
  typedef enum logic [3:0] {
    ST_LEN = 4'h0,
    ST_SUM = 4'h1,
    ST_DATA = 4'h2,
    ST_EXEC = 4'h3,
    ST_ERASE = 4'h4,
    ST_PROG = 4'h5,
    ST_REPLY = 4'h6,
    ST_HOST_ACK = 4'h7,
    ST_ACTION = 4'h8
  } state_t;

  // What the reply sender emits
  typedef enum logic [1:0] {
    RK_ACK = 2'h0,
    RK_NAK = 2'h1,
    RK_STATUS = 2'h2
  } reply_kind_t;

  // Work left after the acknowledge has gone out
  typedef enum logic [1:0] {
    AFTER_NONE = 2'h0,
    AFTER_STATUS = 2'h1,
    AFTER_RUN = 2'h2,
    AFTER_RESET = 2'h3
  } after_t;

  // One flash programming request
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] data;
  } flash_cmd_t;

  // One erase request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] size;
  } erase_cmd_t;

endpackage : boot_loader_pkg

// File: hdl/packet_sum.sv
`timescale 1ns/10ps
// Running modulo-256 sum of the data bytes of one packet
module packet_sum (
  input wire logic clk,
  input wire logic srst,
  input wire logic clear,
  input wire logic add,
  input wire logic [7:0] byte_in,
  output logic [7:0] sum
);

  // Wraps naturally at eight bits
  always_ff @(posedge clk) begin
    if (srst || clear) begin
      sum <= 8'h00;
    end else if (add) begin
      sum <= sum + byte_in;
    end
  end

endmodule : packet_sum

// File: hdl/reply_sender.sv
`timescale 1ns/10ps
`include "boot_loader_defs.svh"
// Emits an acknowledge or NAK byte, or a one-byte status packet
module reply_sender (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire boot_loader_pkg::reply_kind_t kind,
  input wire logic [7:0] status,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic done
);

  logic [1:0] left_reg; // Bytes still to go after the current one
  logic [7:0] stat_reg; // Status captured at start

  // Byte sequencing; no filler is used, so the packet runs unbroken
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_valid <= 1'b0;
      tx_data <= `FILL_BYTE;
      left_reg <= 2'h0;
      stat_reg <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !tx_valid) begin
        tx_valid <= 1'b1;
        stat_reg <= status;
        unique case (kind)
          boot_loader_pkg::RK_ACK: begin
            tx_data <= `ACK_BYTE;
            left_reg <= 2'h0;
          end
          boot_loader_pkg::RK_NAK: begin
            tx_data <= `NAK_BYTE;
            left_reg <= 2'h0;
          end
          default: begin
            // Length first, then sum, then the data byte
            tx_data <= `LEN_STATUS_REPLY;
            left_reg <= 2'h2;
          end
        endcase
      end else if (tx_valid && tx_ready) begin
        if (left_reg == 2'h0) begin
          tx_valid <= 1'b0;
          done <= 1'b1;
        end else begin
          // Sum of one byte is the byte itself
          tx_data <= stat_reg;
          left_reg <= left_reg - 2'h1;
        end
      end
    end
  end

endmodule : reply_sender

// File: hdl/serial_boot_packet_loader.sv
`timescale 1ns/10ps
`include "boot_loader_defs.svh"
// Contract
// - Answer packet with 0xCC good, 0x33 bad
// - Acknowledge reflects reception only, not command
// - Reply packet: length, sum, then data
// - Reply bytes sent back to back
// - Ignore zero bytes awaiting host answer
// - First data byte is the command code
// - Ping acknowledges and sets success status
// - Status query returns one-byte status packet
// - Download latches address and count, MSB first
// - Download erases region before acknowledging
// - Data transfer programs and advances address
// - Programming ends when count reached
// - NAKed data packet leaves address unchanged
// - Run acknowledges, then jumps to address
// - Reset acknowledges, then resets software
// - Length byte counts whole packet
// - Sum byte covers data bytes only
module serial_boot_packet_loader #(
  parameter int BUF_DEPTH = 9 // Command byte plus eight payload bytes
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic erase_req,
  output boot_loader_pkg::erase_cmd_t erase_cmd,
  input wire logic erase_done,
  input wire logic erase_ok,
  output logic prog_req,
  output boot_loader_pkg::flash_cmd_t prog_cmd,
  input wire logic prog_done,
  input wire logic prog_ok,
  output logic run_req,
  output logic [31:0] run_addr,
  output logic sw_reset_req,
  output logic [7:0] status
);

  boot_loader_pkg::state_t state_reg; // Sequencer state
  boot_loader_pkg::after_t after_reg; // Work pending after ack
  logic [7:0] len_reg; // Received length byte
  logic [7:0] rx_sum_reg; // Received sum byte
  logic [7:0] idx_reg; // Data bytes received so far
  logic [7:0] prog_idx_reg; // Next payload byte to program
  logic bad_len_reg; // Length unusable or buffer overrun
  logic [7:0] buf_mem [BUF_DEPTH]; // Data bytes of the packet
  logic [31:0] dl_addr_reg; // Current programming address
  logic [31:0] dl_left_reg; // Bytes still owed by the host
  logic dl_active_reg; // A download is open
  logic prog_wait_reg; // Programming request outstanding
  logic reply_start; // Launch the reply sender
  boot_loader_pkg::reply_kind_t reply_kind;
  logic reply_done;
  logic sum_clear;
  logic sum_add;
  logic [7:0] calc_sum;
  logic rx_last; // Current byte completes the packet
  logic [7:0] data_len; // Length minus header bytes
  logic [31:0] par_a; // Bytes 1..4 of the data, MSB first
  logic [31:0] par_b; // Bytes 5..8 of the data, MSB first

  assign data_len = len_reg - `LEN_HEADER;
  assign rx_last = (idx_reg + 8'h01 == data_len);
  assign par_a = {buf_mem[1], buf_mem[2], buf_mem[3], buf_mem[4]};
  assign par_b = {buf_mem[5], buf_mem[6], buf_mem[7], buf_mem[8]};

  // Sum only data bytes; length and sum bytes are kept out
  assign sum_clear = (state_reg == boot_loader_pkg::ST_LEN);
  assign sum_add = rx_valid && (state_reg == boot_loader_pkg::ST_DATA);

  packet_sum u_sum (
    .clk(clk),
    .srst(srst),
    .clear(sum_clear),
    .add(sum_add),
    .byte_in(rx_data),
    .sum(calc_sum)
  );

  reply_sender u_reply (
    .clk(clk),
    .srst(srst),
    .start(reply_start),
    .kind(reply_kind),
    .status(status),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .done(reply_done)
  );

  // Payload storage; bytes past the buffer are dropped but still summed
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_mem[i] <= 8'h00;
      end
    end else if (sum_add && (idx_reg < 8'(BUF_DEPTH))) begin
      buf_mem[idx_reg[3:0]] <= rx_data;
    end
  end

  // Main packet sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= boot_loader_pkg::ST_LEN;
      after_reg <= boot_loader_pkg::AFTER_NONE;
      len_reg <= 8'h00;
      rx_sum_reg <= 8'h00;
      idx_reg <= 8'h00;
      bad_len_reg <= 1'b0;
      reply_start <= 1'b0;
      reply_kind <= boot_loader_pkg::RK_ACK;
    end else begin
      reply_start <= 1'b0;
      unique case (state_reg)
        boot_loader_pkg::ST_LEN: begin
          // Leading zeros are filler, not a packet
          idx_reg <= 8'h00;
          after_reg <= boot_loader_pkg::AFTER_NONE;
          if (rx_valid && rx_data != `FILL_BYTE) begin
            len_reg <= rx_data;
            bad_len_reg <= (rx_data < `LEN_MIN) ||
                           (rx_data > 8'(BUF_DEPTH + 2));
            state_reg <= boot_loader_pkg::ST_SUM;
          end
        end
        boot_loader_pkg::ST_SUM: begin
          if (rx_valid) begin
            rx_sum_reg <= rx_data;
            // A too-short packet carries no data: answer at once
            if (len_reg < `LEN_MIN) begin
              reply_kind <= boot_loader_pkg::RK_NAK;
              reply_start <= 1'b1;
              state_reg <= boot_loader_pkg::ST_REPLY;
            end else begin
              state_reg <= boot_loader_pkg::ST_DATA;
            end
          end
        end
        boot_loader_pkg::ST_DATA: begin
          if (rx_valid) begin
            idx_reg <= idx_reg + 8'h01;
            if (rx_last) begin
              state_reg <= boot_loader_pkg::ST_EXEC;
            end
          end
        end
        boot_loader_pkg::ST_EXEC: begin
          // Bad packets are never executed, so the address holds
          if (bad_len_reg || calc_sum != rx_sum_reg) begin
            reply_kind <= boot_loader_pkg::RK_NAK;
            reply_start <= 1'b1;
            state_reg <= boot_loader_pkg::ST_REPLY;
          end else begin
            reply_kind <= boot_loader_pkg::RK_ACK;
            unique case (buf_mem[0])
              `CMD_DOWNLOAD: begin
                if (len_reg == `LEN_DOWNLOAD && par_b != 32'h0) begin
                  state_reg <= boot_loader_pkg::ST_ERASE;
                end else begin
                  reply_start <= 1'b1;
                  state_reg <= boot_loader_pkg::ST_REPLY;
                end
              end
              `CMD_SEND_DATA: begin
                if (dl_active_reg) begin
                  state_reg <= boot_loader_pkg::ST_PROG;
                end else begin
                  reply_start <= 1'b1;
                  state_reg <= boot_loader_pkg::ST_REPLY;
                end
              end
              `CMD_STATUS_QUERY: begin
                after_reg <= boot_loader_pkg::AFTER_STATUS;
                reply_start <= 1'b1;
                state_reg <= boot_loader_pkg::ST_REPLY;
              end
              `CMD_RUN: begin
                if (len_reg == `LEN_RUN) begin
                  after_reg <= boot_loader_pkg::AFTER_RUN;
                end
                reply_start <= 1'b1;
                state_reg <= boot_loader_pkg::ST_REPLY;
              end
              `CMD_RESET: begin
                after_reg <= boot_loader_pkg::AFTER_RESET;
                reply_start <= 1'b1;
                state_reg <= boot_loader_pkg::ST_REPLY;
              end
              default: begin
                // Ping and unknown codes only need the acknowledge
                reply_start <= 1'b1;
                state_reg <= boot_loader_pkg::ST_REPLY;
              end
            endcase
          end
        end
        boot_loader_pkg::ST_ERASE: begin
          // Acknowledge waits for the whole erase to finish
          if (erase_done) begin
            reply_start <= 1'b1;
            state_reg <= boot_loader_pkg::ST_REPLY;
          end
        end
        boot_loader_pkg::ST_PROG: begin
          // Done when the payload is used up, count is met, or error
          if (prog_done && !prog_ok) begin
            reply_start <= 1'b1;
            state_reg <= boot_loader_pkg::ST_REPLY;
          end else if (!prog_wait_reg && !prog_req &&
                       (prog_idx_reg >= data_len ||
                        dl_left_reg == 32'h0)) begin
            reply_start <= 1'b1;
            state_reg <= boot_loader_pkg::ST_REPLY;
          end
        end
        boot_loader_pkg::ST_REPLY: begin
          if (reply_done) begin
            unique case (after_reg)
              boot_loader_pkg::AFTER_STATUS: begin
                // Acknowledge is out; now the status packet
                reply_kind <= boot_loader_pkg::RK_STATUS;
                reply_start <= 1'b1;
                after_reg <= boot_loader_pkg::AFTER_NONE;
                state_reg <= boot_loader_pkg::ST_HOST_ACK;
              end
              boot_loader_pkg::AFTER_RUN,
              boot_loader_pkg::AFTER_RESET: begin
                state_reg <= boot_loader_pkg::ST_ACTION;
              end
              default: begin
                state_reg <= boot_loader_pkg::ST_LEN;
              end
            endcase
          end
        end
        boot_loader_pkg::ST_HOST_ACK: begin
          // Any non-zero byte after the packet is the host's answer;
          // a NAK needs nothing here, the host repeats the query
          if (rx_valid && rx_data != `FILL_BYTE && !tx_valid) begin
            state_reg <= boot_loader_pkg::ST_LEN;
          end
        end
        boot_loader_pkg::ST_ACTION: begin
          state_reg <= boot_loader_pkg::ST_LEN;
        end
        default: begin
          state_reg <= boot_loader_pkg::ST_LEN;
        end
      endcase
    end
  end

  // Download target, address advance and remaining count
  always_ff @(posedge clk) begin
    if (srst) begin
      dl_addr_reg <= 32'h0;
      dl_left_reg <= 32'h0;
      dl_active_reg <= 1'b0;
    end else if (state_reg == boot_loader_pkg::ST_EXEC &&
                 !bad_len_reg && calc_sum == rx_sum_reg &&
                 buf_mem[0] == `CMD_DOWNLOAD) begin
      dl_addr_reg <= par_a;
      dl_left_reg <= par_b;
      dl_active_reg <= (len_reg == `LEN_DOWNLOAD) && (par_b != 32'h0);
    end else if (state_reg == boot_loader_pkg::ST_ERASE &&
                 erase_done && !erase_ok) begin
      dl_active_reg <= 1'b0;
    end else if (state_reg == boot_loader_pkg::ST_PROG && prog_done) begin
      if (prog_ok) begin
        dl_addr_reg <= dl_addr_reg + 32'h1;
        dl_left_reg <= dl_left_reg - 32'h1;
        // Last owed byte closes the programming sequence
        if (dl_left_reg == 32'h1) begin
          dl_active_reg <= 1'b0;
        end
      end else begin
        dl_active_reg <= 1'b0;
      end
    end
  end

  // Flash requests: erase once, program one byte at a time
  always_ff @(posedge clk) begin
    if (srst) begin
      erase_req <= 1'b0;
      erase_cmd <= '0;
      prog_req <= 1'b0;
      prog_cmd <= '0;
      prog_wait_reg <= 1'b0;
      prog_idx_reg <= 8'h01;
    end else begin
      erase_req <= 1'b0;
      prog_req <= 1'b0;
      if (state_reg == boot_loader_pkg::ST_EXEC) begin
        erase_cmd.addr <= par_a;
        erase_cmd.size <= par_b;
        erase_req <= !bad_len_reg && calc_sum == rx_sum_reg &&
                     buf_mem[0] == `CMD_DOWNLOAD &&
                     len_reg == `LEN_DOWNLOAD && par_b != 32'h0;
        prog_idx_reg <= 8'h01;
        prog_wait_reg <= 1'b0;
      end else if (state_reg == boot_loader_pkg::ST_PROG) begin
        if (prog_done) begin
          prog_wait_reg <= 1'b0;
          prog_idx_reg <= prog_idx_reg + 8'h01;
        end else if (!prog_wait_reg && !prog_req &&
                     prog_idx_reg < data_len &&
                     dl_left_reg != 32'h0) begin
          prog_cmd.addr <= dl_addr_reg;
          prog_cmd.data <= buf_mem[prog_idx_reg[3:0]];
          prog_req <= 1'b1;
          prog_wait_reg <= 1'b1;
        end
      end
    end
  end

  // Global status, updated only by correctly received packets
  always_ff @(posedge clk) begin
    if (srst) begin
      status <= `STAT_RESET;
    end else if (state_reg == boot_loader_pkg::ST_EXEC &&
                 !bad_len_reg && calc_sum == rx_sum_reg) begin
      unique case (buf_mem[0])
        `CMD_PING: status <= `STAT_SUCCESS;
        `CMD_STATUS_QUERY: status <= status;
        `CMD_DOWNLOAD: status <= (len_reg == `LEN_DOWNLOAD &&
                                  par_b != 32'h0) ?
                                 `STAT_SUCCESS : `STAT_INVALID_CMD;
        `CMD_SEND_DATA: status <= dl_active_reg ?
                                  `STAT_SUCCESS :
                                  `STAT_INVALID_CMD;
        `CMD_RUN: status <= (len_reg == `LEN_RUN) ?
                            `STAT_SUCCESS : `STAT_INVALID_CMD;
        `CMD_RESET: status <= `STAT_SUCCESS;
        default: status <= `STAT_UNKNOWN_CMD;
      endcase
    end else if (state_reg == boot_loader_pkg::ST_ERASE &&
                 erase_done && !erase_ok) begin
      status <= `STAT_FLASH_FAIL;
    end else if (state_reg == boot_loader_pkg::ST_PROG &&
                 prog_done && !prog_ok) begin
      status <= `STAT_FLASH_FAIL;
    end else if (state_reg == boot_loader_pkg::ST_PROG &&
                 !prog_wait_reg && !prog_req &&
                 dl_left_reg == 32'h0 && prog_idx_reg < data_len) begin
      // Host sent more bytes than the download announced
      status <= `STAT_INVALID_CMD;
    end
  end

  // Jump and reset fire only after the acknowledge has left
  always_ff @(posedge clk) begin
    if (srst) begin
      run_req <= 1'b0;
      run_addr <= 32'h0;
      sw_reset_req <= 1'b0;
    end else begin
      run_req <= 1'b0;
      sw_reset_req <= 1'b0;
      if (state_reg == boot_loader_pkg::ST_ACTION) begin
        if (after_reg == boot_loader_pkg::AFTER_RUN) begin
          run_req <= 1'b1;
          run_addr <= par_a;
        end else begin
          sw_reset_req <= 1'b1;
        end
      end
    end
  end

endmodule : serial_boot_packet_loader

// File: verification/loader_checker_assertions.sv
`timescale 1ns/10ps
`include "boot_loader_defs.svh"
// Port-level timing checks of the packet loader
module loader_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic erase_req,
  input wire logic erase_done,
  input wire logic prog_req,
  input wire logic prog_done,
  input wire logic run_req,
  input wire logic sw_reset_req
);
  logic ack_go; // Acknowledge byte taken by the port this cycle
  assign ack_go = tx_valid && tx_ready && (tx_data == `ACK_BYTE);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // An offered byte waits unchanged until the port takes it
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx byte dropped or changed before accept");
  // No filler is ever offered, so zero never shows
  property p_no_filler;
    tx_valid |-> tx_data != `FILL_BYTE;
  endproperty
  a_no_filler: assert property (p_no_filler)
    else $error("zero byte offered on tx");
  // Jump only after the acknowledge has left: accept edge, done edge,
  // action edge, then the pulse is seen, so three samples back
  property p_run_after_ack;
    run_req |-> $past(ack_go, 3);
  endproperty
  a_run_after_ack: assert property (p_run_after_ack)
    else $error("run request without prior acknowledge");
  property p_reset_after_ack;
    sw_reset_req |-> $past(ack_go, 3);
  endproperty
  a_reset_after_ack: assert property (p_reset_after_ack)
    else $error("software reset without prior acknowledge");
  // Download acknowledge follows the erase result; start pulse costs one
  property p_ack_after_erase;
    erase_done |-> ##2 (tx_valid && tx_data == `ACK_BYTE);
  endproperty
  a_ack_after_erase: assert property (p_ack_after_erase)
    else $error("no acknowledge right after erase finished");
  property p_erase_quiet;
    erase_req |=> (!tx_valid) [*2];
  endproperty
  a_erase_quiet: assert property (p_erase_quiet)
    else $error("answer sent while erase still running");
  // Flash writes are spaced and never requested while an answer is offered
  property p_prog_gap;
    prog_done |-> !prog_req ##1 !prog_req;
  endproperty
  a_prog_gap: assert property (p_prog_gap)
    else $error("program request too close to previous done");
  property p_prog_quiet;
    prog_req |-> !tx_valid;
  endproperty
  a_prog_quiet: assert property (p_prog_quiet)
    else $error("program request while answer pending");
  property p_one_req;
    $onehot0({erase_req, prog_req, run_req, sw_reset_req});
  endproperty
  a_one_req: assert property (p_one_req)
    else $error("two action requests in one cycle");
endmodule : loader_checker

bind serial_boot_packet_loader loader_checker u_chk (.clk(clk),
  .srst(srst), .tx_ready(tx_ready), .tx_valid(tx_valid),
  .tx_data(tx_data), .erase_req(erase_req), .erase_done(erase_done),
  .prog_req(prog_req), .prog_done(prog_done), .run_req(run_req),
  .sw_reset_req(sw_reset_req));

// File: verification/flash_model.sv
`timescale 1ns/10ps
// Flash array stand-in: answers erase and program after a delay
module flash_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic fail,
  input wire logic erase_req,
  input wire logic prog_req,
  input wire boot_loader_pkg::flash_cmd_t prog_cmd,
  output logic erase_done,
  output logic erase_ok,
  output logic prog_done,
  output logic prog_ok
);
  logic [7:0] mem [logic [31:0]]; // Programmed bytes by address
  int wait_cnt; // Cycles left on the current job
  logic is_prog; // Current job is a byte program
  // One job at a time; slow mode stretches it to show stalls
  always @(posedge clk) begin
    erase_done <= 1'b0;
    prog_done <= 1'b0;
    if (srst) begin
      wait_cnt <= 0;
    end else if (erase_req || prog_req) begin
      wait_cnt <= slow ? 6 : 1;
      is_prog <= prog_req;
      if (prog_req && !fail) begin
        mem[prog_cmd.addr] = prog_cmd.data;
      end
    end else if (wait_cnt == 1) begin
      wait_cnt <= 0;
      erase_done <= !is_prog;
      prog_done <= is_prog;
    end else if (wait_cnt > 1) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
  // Result flags are garbage outside the done pulse
  assign erase_ok = erase_done ? !fail : fail;
  assign prog_ok = prog_done ? !fail : fail;
endmodule : flash_model

// File: verification/serial_boot_packet_loader_test.sv
`timescale 1ns/10ps
`include "boot_loader_defs.svh"
// Host-side bench: sends packets, checks answers and flash writes
module serial_boot_packet_loader_test;
  logic clk, srst, rx_valid, tx_ready, tx_valid, slow, fail;
  logic [7:0] rx_data, tx_data, status, b;
  logic erase_req, erase_done, erase_ok, prog_req, prog_done, prog_ok;
  logic run_req, sw_reset_req;
  logic [31:0] run_addr, run_seen, a;
  boot_loader_pkg::erase_cmd_t erase_cmd, er_seen;
  boot_loader_pkg::flash_cmd_t prog_cmd;
  logic [7:0] pkt[$]; // Data bytes of the next packet
  logic [7:0] img[$]; // Bytes the flash should now hold
  int mismatches, cmp_count, cycles, n_run, n_rst, n_prog, st, i;
  integer seed = 32'h27975AB1;

  serial_boot_packet_loader u_dut (.clk(clk), .srst(srst),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .erase_req(erase_req),
    .erase_cmd(erase_cmd), .erase_done(erase_done), .erase_ok(erase_ok),
    .prog_req(prog_req), .prog_cmd(prog_cmd), .prog_done(prog_done),
    .prog_ok(prog_ok), .run_req(run_req), .run_addr(run_addr),
    .sw_reset_req(sw_reset_req), .status(status));
  flash_model u_flash (.clk(clk), .srst(srst), .slow(slow), .fail(fail),
    .erase_req(erase_req), .prog_req(prog_req), .prog_cmd(prog_cmd),
    .erase_done(erase_done), .erase_ok(erase_ok),
    .prog_done(prog_done), .prog_ok(prog_ok));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Port stalls at random; actions are logged; hang guard
  always @(posedge clk) begin
    tx_ready <= ($random(seed) & 3) != 0;
    cycles++;
    if (erase_req === 1'b1) er_seen <= erase_cmd;
    if (prog_req === 1'b1) n_prog++;
    if (sw_reset_req === 1'b1) n_rst++;
    if (run_req === 1'b1) begin
      n_run++;
      run_seen <= run_addr;
    end
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  task check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One byte, then the line shows junk while idle
  task send_byte(input logic [7:0] v);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= v;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~v;
  endtask : send_byte

  // Length, sum (optionally spoiled), then data bytes
  task send_pkt(input bit bad);
    logic [7:0] s;
    s = {7'h00, bad};
    foreach (pkt[k]) s += pkt[k];
    send_byte(8'(pkt.size() + 2));
    send_byte(s);
    foreach (pkt[k]) send_byte(pkt[k]);
  endtask : send_pkt

  // Sampled at the falling edge so the handshake edge is known
  task get_byte();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(tx_valid === 1'b1 && tx_ready === 1'b1) && n < 300);
    b = tx_data;
    @(posedge clk);
  endtask : get_byte

  task cmd(input bit bad, input logic [7:0] e);
    send_pkt(bad);
    get_byte();
    check("answer", b, e);
  endtask : cmd

  // Query, read the status packet, answer it after a filler
  task query(input int e, input bit nak);
    pkt = {`CMD_STATUS_QUERY};
    cmd(1'b0, `ACK_BYTE);
    get_byte();
    check("reply len", b, `LEN_STATUS_REPLY);
    get_byte();
    check("reply sum", b, 8'(e));
    get_byte();
    check("reply status", b, 8'(e));
    check("status port", status, 8'(e));
    send_byte(`FILL_BYTE);
    send_byte(nak ? `NAK_BYTE : `ACK_BYTE);
  endtask : query

  task end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    srst = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    slow = 1'b0;
    fail = 1'b0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    pkt = {`CMD_PING};
    cmd(1'b0, `ACK_BYTE);
    st = `STAT_SUCCESS;
    query(st, 1'b1);
    query(st, 1'b0);
    $display("Test ping and status done");
    pkt = {8'h2F};
    cmd(1'b0, `ACK_BYTE);
    st = `STAT_UNKNOWN_CMD;
    query(st, 1'b0);
    pkt = {`CMD_PING};
    cmd(1'b1, `NAK_BYTE);
    query(st, 1'b0);
    pkt = {`CMD_SEND_DATA, 8'h5A};
    cmd(1'b0, `ACK_BYTE);
    st = `STAT_INVALID_CMD;
    query(st, 1'b0);
    $display("Test refusals done");
    a = $random(seed);
    slow <= 1'b1;
    pkt = {`CMD_DOWNLOAD, a[31:24], a[23:16], a[15:8], a[7:0],
      8'h00, 8'h00, 8'h00, 8'h0C};
    cmd(1'b0, `ACK_BYTE);
    check("erase addr", er_seen.addr, a);
    check("erase size", er_seen.size, 32'h0000000C);
    st = `STAT_SUCCESS;
    query(st, 1'b0);
    pkt = {`CMD_SEND_DATA};
    for (i = 0; i < 8; i++) pkt.push_back(8'($random(seed)));
    cmd(1'b1, `NAK_BYTE);
    cmd(1'b0, `ACK_BYTE);
    img = pkt[1:$];
    query(st, 1'b0);
    pkt = {`CMD_SEND_DATA};
    for (i = 0; i < 4; i++) pkt.push_back(8'($random(seed)));
    cmd(1'b0, `ACK_BYTE);
    img = {img, pkt[1:$]};
    query(st, 1'b0);
    for (i = 0; i < 12; i++) begin
      check("flash byte", u_flash.mem[a + i], img[i]);
    end
    pkt = {`CMD_SEND_DATA, 8'hA5};
    cmd(1'b0, `ACK_BYTE);
    st = `STAT_INVALID_CMD;
    query(st, 1'b0);
    check("program count", n_prog, 12);
    $display("Test download done");
    a = $random(seed);
    pkt = {`CMD_RUN, a[31:24], a[23:16], a[15:8], a[7:0]};
    cmd(1'b0, `ACK_BYTE);
    repeat (4) @(posedge clk);
    check("run count", n_run, 1);
    check("run addr", run_seen, a);
    pkt = {`CMD_RESET};
    cmd(1'b0, `ACK_BYTE);
    repeat (4) @(posedge clk);
    check("reset count", n_rst, 1);
    $display("Test run and reset done");
    // A failed erase still gets the acknowledge; only status tells
    fail <= 1'b1;
    pkt = {`CMD_DOWNLOAD, a[31:24], a[23:16], a[15:8], a[7:0],
      8'h00, 8'h00, 8'h00, 8'h04};
    cmd(1'b0, `ACK_BYTE);
    st = `STAT_FLASH_FAIL;
    query(st, 1'b0);
    $display("Test flash failure done");
    end_of_test();
  end
endmodule : serial_boot_packet_loader_test
